/* core/epm_pkg.sv */
package epm_pkg;
  // ------------------------------------------------------------
  // i/o port map
  // ------------------------------------------------------------
  localparam logic [15:0] IO_PAGE_INDEX = 16'h00e8;
  localparam logic [15:0] IO_PAGE_LO    = 16'h00ea;
  localparam logic [15:0] IO_PAGE_HI    = 16'h00eb;
  localparam logic [15:0] IO_CFG_INDEX  = 16'h00ec;
  localparam logic [15:0] IO_CFG_DATA   = 16'h00ed;
  localparam logic [15:0] IO_LOCK       = 16'h00f9;
  localparam logic [15:0] IO_UNLOCK     = 16'h00fb;

  // ------------------------------------------------------------
  // configuration indices behind the data port
  // ------------------------------------------------------------
  localparam logic [7:0] CFG_MAP_EN_PRI  = 8'h10;
  localparam logic [7:0] CFG_MAP_EN_SEC  = 8'h11;
  localparam logic [7:0] CFG_SLOT_PTR    = 8'h12;
  localparam logic [7:0] CFG_SHADOW_BASE = 8'h13;
  localparam logic [7:0] CFG_SHADOW_LAST = 8'h18;
  localparam logic [7:0] CFG_CTX_SELECT  = 8'h19;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int IDX_BANK_BIT  = 7;
  localparam int IDX_AUTO_BIT  = 6;
  localparam int EN1_GLOBAL    = 7;
  localparam int EN1_BACKFILL  = 6;
  localparam int EN1_RELOCATE  = 4;

  // ------------------------------------------------------------
  // sizes and reset values
  // ------------------------------------------------------------
  localparam int          NUM_REGS      = 72;
  localparam logic [5:0]  REGS_PER_BANK = 6'd36;
  localparam logic [5:0]  LAST_REG_NUM  = 6'd35;
  localparam int          PAGE_W        = 11;
  localparam logic [4:0]  PAGE_HI_ONES  = 5'h1f;
  localparam logic [7:0]  UNMAPPED_READ = 8'hff;
  localparam logic [7:0]  SLOT_PTR_RST  = 8'hff;
  localparam logic [7:0]  MAP_EN_RST    = 8'h00;
  localparam logic [7:0]  SHADOW_RST    = 8'h00;
  localparam logic [7:0]  INDEX_RST     = 8'h00;

  // ------------------------------------------------------------
  // address decode constants (64k segment numbers, a[23:16])
  // ------------------------------------------------------------
  localparam logic [7:0] SLT_BF_CLR_LO = 8'h04;
  localparam logic [7:0] SLT_BF_CLR_HI = 8'h09;
  localparam logic [7:0] SLT_ALIAS_LO  = 8'h0a;
  localparam logic [7:0] SLT_ALIAS_HI  = 8'h0f;
  localparam logic [7:0] SEG_1M        = 8'h10;
  localparam logic [7:0] SEG_BF_LO     = 8'h04;
  localparam logic [7:0] SEG_BF_HI     = 8'h09;
  localparam logic [6:0] SEG_ROM_PAIR  = 7'h7f;
  localparam logic [5:0] BF_WIN_OFFSET = 6'h04;
  localparam logic [3:0] SEG_A = 4'ha;
  localparam logic [3:0] SEG_B = 4'hb;
  localparam logic [3:0] SEG_C = 4'hc;
  localparam logic [3:0] SEG_D = 4'hd;
  localparam logic [3:0] SEG_E = 4'he;
  localparam logic [3:0] SEG_F = 4'hf;

  // ------------------------------------------------------------
  // shadow codes and destinations
  // ------------------------------------------------------------
  localparam logic [1:0] SH_SLOT     = 2'b00;
  localparam logic [1:0] SH_SETUP    = 2'b01;
  localparam logic [1:0] SH_RD_BOARD = 2'b10;
  localparam logic [1:0] SH_BOARD    = 2'b11;

  typedef enum logic [1:0] {
    DEST_BOARD = 2'b00,
    DEST_SLOT  = 2'b01,
    DEST_ROM   = 2'b10
  } epm_dest_e;
endpackage

/* core/epm_page_mem.sv */
`timescale 1ns/1ps
// 72 x 11 page storage, one write port with byte lanes, two registered read ports
module epm_page_mem
  import epm_pkg::*;
(
  // clock
  input  wire logic              clk,
  // write port
  input  wire logic              we_lo,
  input  wire logic              we_hi,
  input  wire logic [6:0]        waddr,
  input  wire logic [7:0]        wdata,
  // software read port
  input  wire logic [6:0]        ra_addr,
  output logic      [PAGE_W-1:0] ra_data_r,
  // translation read port
  input  wire logic [6:0]        rb_addr,
  output logic      [PAGE_W-1:0] rb_data_r
);
  logic [PAGE_W-1:0] mem [NUM_REGS];

  // ------------------------------------------------------------
  // byte-lane writes; high lane holds only a24..a22
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (we_lo) begin
      mem[waddr][7:0] <= wdata;
    end
    if (we_hi) begin
      mem[waddr][10:8] <= wdata[2:0];
    end
  end

  // registered reads; old data on a same-cycle write
  always_ff @(posedge clk) begin
    ra_data_r <= mem[ra_addr];
    rb_data_r <= mem[rb_addr];
  end
endmodule

/* core/epm_mapper.sv */
`timescale 1ns/1ps
//
// Behaviour
// - 72 page-mapping registers in two banks of 36, standard and alternate.
// - per bank 12 page registers for c0000-effff, 24 backfill for 40000-9ffff.
// - primary enable bit 7 gates all translation; clear means no translation.
// - twelve page windows each enabled by secondary[7:0] and primary[3:0].
// - backfill registers enabled together by primary bit 6 only.
// - with global enable clear the backfill bit has no effect.
// - primary bit 4 moves page windows to a, d, b segments in order.
// - when moved, primary[3:0] enables b windows, secondary[3:0] a windows.
// - writing slot pointer 04h..09h clears the backfill enable bit.
// - slot pointer 0ah..0fh decodes as 10h.
// - pointer below 1m: below pointer is board, pointer to 16m is slot.
// - pointer 1m or more: 1m to pointer board, pointer to 16m slot.
// - pointer 1m or more: below 640k board, backfill translates 256k-640k.
// - mapping off, a0000-fffff destination comes only from shadow codes.
// - active page window overrides shadow, accesses always translated.
// - translation targets on-board dram anywhere in 32 mbyte range.
// - shadow codes 00 slot/rom, 10 rd board wr slot, 11 board, 01 setup.
// - global and window enable set: shadow ignored, access translated.
// - global on, window enable off: decode as if mapping disabled.
// - index port: bit 7 bank, bit 6 auto-increment, bits 5:0 number.
// - page data a24..a14 in bits 10:0, 15:11 read one; low ea, high eb.
// - auto-increment advances number on each high byte access; low first.
// - write fbh unlocks, f9h relocks; register writes ignored while locked.
// - numbers 0-11 page registers, 12-35 backfill, in selected bank.
//
module epm_mapper
  import epm_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // i/o port bus
  input  wire logic [15:0] io_addr,
  input  wire logic        io_rd,
  input  wire logic        io_wr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata_r,
  output logic             io_ack_r,
  // cpu memory cycle in
  input  wire logic        cpu_valid,
  input  wire logic        cpu_wr,
  input  wire logic [23:0] cpu_addr,
  // decoded memory cycle out
  output logic             mem_valid_r,
  output logic             mem_wr_r,
  output logic             mem_translated_r,
  output epm_dest_e        mem_dest_r,
  output logic      [24:0] mem_phys_r
);
  // ------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [7:0]      page_index_select_r;
  logic [7:0]      cfg_index_r;
  logic [7:0]      map_enable_primary_r;
  logic [7:0]      map_enable_secondary_r;
  logic [7:0]      slot_boundary_pointer_r;
  logic [7:0]      shadow_ctrl_r [6];
  logic            ctx_select_r;
  logic            unlocked_r;
  logic [PAGE_W-1:0] page_rd;
  logic [PAGE_W-1:0] page_tr;

  logic [5:0] reg_num;
  logic       num_ok;
  logic       hi_access;
  logic       wr_ok;
  logic       we_lo;
  logic       we_hi;
  logic [6:0] sw_mem_addr;

  assign reg_num   = page_index_select_r[5:0];
  assign num_ok    = (reg_num <= LAST_REG_NUM);
  assign wr_ok     = io_wr && unlocked_r;
  assign hi_access = (io_addr == IO_PAGE_HI) && (io_rd || wr_ok);
  assign we_lo     = wr_ok && (io_addr == IO_PAGE_LO) && num_ok;
  assign we_hi     = wr_ok && (io_addr == IO_PAGE_HI) && num_ok;
  // bank picks upper or lower 36 entries
  assign sw_mem_addr = page_index_select_r[IDX_BANK_BIT] ?
                       7'({1'b0, reg_num} + {1'b0, REGS_PER_BANK}) : {1'b0, reg_num};

  // lock gate; unlock and relock are plain port writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      unlocked_r <= 1'b0;
    end else if (io_wr && io_addr == IO_UNLOCK) begin
      unlocked_r <= 1'b1;
    end else if (io_wr && io_addr == IO_LOCK) begin
      unlocked_r <= 1'b0;
    end
  end

  // index port with auto-increment on each high byte access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      page_index_select_r <= INDEX_RST;
    end else if (wr_ok && io_addr == IO_PAGE_INDEX) begin
      page_index_select_r <= io_wdata;
    end else if (hi_access && page_index_select_r[IDX_AUTO_BIT]) begin
      // wrap keeps the number inside the bank
      page_index_select_r[5:0] <= (reg_num >= LAST_REG_NUM) ? 6'h00 : reg_num + 6'h01;
    end
  end

  // configuration index and plain config registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_index_r             <= INDEX_RST;
      map_enable_secondary_r  <= MAP_EN_RST;
      slot_boundary_pointer_r <= SLOT_PTR_RST;
      ctx_select_r            <= 1'b0;
    end else if (wr_ok && io_addr == IO_CFG_INDEX) begin
      cfg_index_r <= io_wdata;
    end else if (wr_ok && io_addr == IO_CFG_DATA) begin
      if (cfg_index_r == CFG_MAP_EN_SEC) begin
        map_enable_secondary_r <= io_wdata;
      end
      if (cfg_index_r == CFG_SLOT_PTR) begin
        slot_boundary_pointer_r <= io_wdata;
      end
      if (cfg_index_r == CFG_CTX_SELECT) begin
        ctx_select_r <= io_wdata[0];
      end
    end
  end

  // primary enable; a pointer write in 04h..09h drops the backfill bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      map_enable_primary_r <= MAP_EN_RST;
    end else if (wr_ok && io_addr == IO_CFG_DATA) begin
      if (cfg_index_r == CFG_MAP_EN_PRI) begin
        map_enable_primary_r <= io_wdata;
      end
      if (cfg_index_r == CFG_SLOT_PTR && io_wdata >= SLT_BF_CLR_LO &&
          io_wdata <= SLT_BF_CLR_HI) begin
        map_enable_primary_r[EN1_BACKFILL] <= 1'b0;
      end
    end
  end

  // six shadow control registers, one per 64k segment a..f
  genvar gs;
  generate
    for (gs = 0; gs < 6; gs++) begin : g_shadow
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          shadow_ctrl_r[gs] <= SHADOW_RST;
        end else if (wr_ok && io_addr == IO_CFG_DATA &&
                     cfg_index_r == 8'(CFG_SHADOW_BASE + 8'(gs))) begin
          shadow_ctrl_r[gs] <= io_wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // read mux and answer
  // ------------------------------------------------------------
  logic [7:0] rd_mux;
  logic       port_hit;

  assign port_hit = (io_addr == IO_PAGE_INDEX) || (io_addr == IO_PAGE_LO) ||
                    (io_addr == IO_PAGE_HI) || (io_addr == IO_CFG_INDEX) ||
                    (io_addr == IO_CFG_DATA) || (io_addr == IO_LOCK) ||
                    (io_addr == IO_UNLOCK);

  always_comb begin
    rd_mux = UNMAPPED_READ;
    if (io_addr == IO_PAGE_INDEX) begin
      rd_mux = page_index_select_r;
    end else if (io_addr == IO_PAGE_LO && num_ok) begin
      rd_mux = page_rd[7:0];
    end else if (io_addr == IO_PAGE_HI && num_ok) begin
      rd_mux = {PAGE_HI_ONES, page_rd[10:8]};
    end else if (io_addr == IO_CFG_INDEX) begin
      rd_mux = cfg_index_r;
    end else if (io_addr == IO_CFG_DATA) begin
      if (cfg_index_r == CFG_MAP_EN_PRI) begin
        rd_mux = map_enable_primary_r;
      end else if (cfg_index_r == CFG_MAP_EN_SEC) begin
        rd_mux = map_enable_secondary_r;
      end else if (cfg_index_r == CFG_SLOT_PTR) begin
        rd_mux = slot_boundary_pointer_r;
      end else if (cfg_index_r == CFG_CTX_SELECT) begin
        rd_mux = {7'h00, ctx_select_r};
      end else if (cfg_index_r >= CFG_SHADOW_BASE && cfg_index_r <= CFG_SHADOW_LAST) begin
        rd_mux = shadow_ctrl_r[3'(cfg_index_r - CFG_SHADOW_BASE)];
      end
    end
  end

  // one-cycle answer for every decoded port access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata_r <= 8'h00;
      io_ack_r   <= 1'b0;
    end else begin
      io_ack_r <= (io_rd || io_wr) && port_hit;
      if (io_rd) begin
        io_rdata_r <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  logic [7:0] eff_ptr;
  logic [7:0] seg_hi;
  logic [3:0] seg;
  logic [1:0] qtr;
  logic       below_1m;
  logic       glob_en;
  logic       in_area;
  logic [1:0] grp;
  logic [3:0] win;
  logic [11:0] win_en;
  logic       page_hit;
  logic       bf_hit;
  logic       translate;
  logic [5:0] tr_num;
  logic [1:0] sh_code;
  logic       rom_space;
  epm_dest_e  direct_dest;

  assign eff_ptr  = (slot_boundary_pointer_r >= SLT_ALIAS_LO &&
                     slot_boundary_pointer_r <= SLT_ALIAS_HI) ? SEG_1M
                    : slot_boundary_pointer_r;
  assign seg_hi   = cpu_addr[23:16];
  assign seg      = cpu_addr[19:16];
  assign qtr      = cpu_addr[15:14];
  assign below_1m = (cpu_addr[23:20] == 4'h0);
  assign glob_en  = map_enable_primary_r[EN1_GLOBAL];
  assign win_en   = {map_enable_primary_r[3:0], map_enable_secondary_r};

  // window group: c/d/e normally, a/d/b when relocated
  always_comb begin
    in_area = below_1m;
    grp     = 2'd0;
    if (map_enable_primary_r[EN1_RELOCATE]) begin
      if (seg == SEG_A) grp = 2'd0;
      else if (seg == SEG_D) grp = 2'd1;
      else if (seg == SEG_B) grp = 2'd2;
      else in_area = 1'b0;
    end else begin
      if (seg == SEG_C) grp = 2'd0;
      else if (seg == SEG_D) grp = 2'd1;
      else if (seg == SEG_E) grp = 2'd2;
      else in_area = 1'b0;
    end
  end

  assign win       = {grp, qtr};
  assign page_hit  = glob_en && in_area && win_en[win];
  // backfill is dead while the global bit is off or pointer is below 0ah
  assign bf_hit    = glob_en && map_enable_primary_r[EN1_BACKFILL] &&
                     eff_ptr >= SEG_1M && seg_hi >= SEG_BF_LO &&
                     seg_hi <= SEG_BF_HI;
  assign translate = page_hit || bf_hit;
  assign tr_num    = page_hit ? {2'b00, win} : cpu_addr[19:14] - BF_WIN_OFFSET;
  assign rom_space = (seg == SEG_E) || (seg == SEG_F);
  assign sh_code   = (seg >= SEG_A) ? shadow_ctrl_r[3'(seg - SEG_A)][{qtr, 1'b0} +: 2] : SH_SLOT;

  // untranslated destination; also used for disabled windows
  always_comb begin
    direct_dest = DEST_SLOT;
    if (below_1m && seg >= SEG_A) begin
      unique case (sh_code)
        SH_SLOT:     direct_dest = rom_space ? DEST_ROM : DEST_SLOT;
        SH_RD_BOARD: direct_dest = cpu_wr ? DEST_SLOT : DEST_BOARD;
        SH_BOARD:    direct_dest = DEST_BOARD;
        SH_SETUP:    direct_dest = cpu_wr ? DEST_BOARD : (rom_space ? DEST_ROM : DEST_SLOT);
      endcase
    end else if (seg_hi[7:1] == SEG_ROM_PAIR) begin
      direct_dest = DEST_ROM;
    end else if (eff_ptr < SEG_1M) begin
      direct_dest = (seg_hi < eff_ptr) ? DEST_BOARD : DEST_SLOT;
    end else if (below_1m) begin
      direct_dest = DEST_BOARD;
    end else begin
      direct_dest = (seg_hi < eff_ptr) ? DEST_BOARD : DEST_SLOT;
    end
  end

  // ------------------------------------------------------------
  // page storage; software port follows the index, cpu port the ctx bank
  // ------------------------------------------------------------
  logic [6:0] tr_mem_addr;

  assign tr_mem_addr = ctx_select_r ? 7'({1'b0, tr_num} + {1'b0, REGS_PER_BANK})
                                    : {1'b0, tr_num};

  epm_page_mem u_mem (
    .clk       (clk),
    .we_lo     (we_lo),
    .we_hi     (we_hi),
    .waddr     (sw_mem_addr),
    .wdata     (io_wdata),
    .ra_addr   (sw_mem_addr),
    .ra_data_r (page_rd),
    .rb_addr   (tr_mem_addr),
    .rb_data_r (page_tr)
  );

  // ------------------------------------------------------------
  // two-stage cycle pipeline: lookup then output
  // ------------------------------------------------------------
  logic        s1_valid_r;
  logic        s1_wr_r;
  logic        s1_trans_r;
  epm_dest_e   s1_dest_r;
  logic [23:0] s1_addr_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_valid_r <= 1'b0;
      s1_wr_r    <= 1'b0;
      s1_trans_r <= 1'b0;
      s1_dest_r  <= DEST_SLOT;
      s1_addr_r  <= 24'h000000;
    end else begin
      s1_valid_r <= cpu_valid;
      s1_wr_r    <= cpu_wr;
      s1_trans_r <= translate;
      s1_dest_r  <= direct_dest;
      s1_addr_r  <= cpu_addr;
    end
  end

  // translated cycles always land in on-board dram
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_valid_r      <= 1'b0;
      mem_wr_r         <= 1'b0;
      mem_translated_r <= 1'b0;
      mem_dest_r       <= DEST_SLOT;
      mem_phys_r       <= 25'h0000000;
    end else begin
      mem_valid_r      <= s1_valid_r;
      mem_wr_r         <= s1_wr_r;
      mem_translated_r <= s1_trans_r;
      mem_dest_r       <= s1_trans_r ? DEST_BOARD : s1_dest_r;
      mem_phys_r       <= s1_trans_r ? {page_tr, s1_addr_r[13:0]}
                                     : {1'b0, s1_addr_r};
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_tr_req;
    cpu_valid && translate;
  endsequence
  sequence s_tr_out;
    mem_valid_r && mem_translated_r && mem_dest_r == DEST_BOARD;
  endsequence

  AST_TRANS_ADDR: assert property (s_tr_req |-> ##2 (s_tr_out and
      (mem_phys_r[13:0] == $past(cpu_addr[13:0], 2))))
    else $error("translated cycle address or timing wrong");
  AST_GLOBAL_OFF: assert property (!glob_en |-> !translate)
    else $error("translation while global enable clear");
  AST_BF_GROUP: assert property (bf_hit |-> map_enable_primary_r[EN1_BACKFILL])
    else $error("backfill hit without backfill enable");
  AST_PAGE_EN: assert property (page_hit |-> win_en[win] && win <= 4'd11)
    else $error("page hit on disabled window");
  AST_BF_CLEAR: assert property (wr_ok && io_addr == IO_CFG_DATA &&
      cfg_index_r == CFG_SLOT_PTR && io_wdata >= SLT_BF_CLR_LO && io_wdata <= SLT_BF_CLR_HI
      |=> !map_enable_primary_r[EN1_BACKFILL])
    else $error("backfill bit not cleared by low pointer");
  AST_PTR_ALIAS: assert property (slot_boundary_pointer_r inside {[8'h0a:8'h0f]}
      |-> eff_ptr == SEG_1M)
    else $error("pointer alias not applied");
  AST_LOCKED_WR: assert property (io_wr && !unlocked_r && io_addr == IO_PAGE_INDEX
      |=> $stable(page_index_select_r))
    else $error("index changed while locked");
  AST_HI_ONES: assert property (io_rd && io_addr == IO_PAGE_HI && num_ok
      |=> io_ack_r && io_rdata_r[7:3] == PAGE_HI_ONES)
    else $error("high byte reserved bits not one");
  AST_AUTO_INC: assert property (io_rd && io_addr == IO_PAGE_HI &&
      page_index_select_r[IDX_AUTO_BIT] && reg_num < LAST_REG_NUM
      |=> reg_num == $past(reg_num) + 6'h01)
    else $error("auto increment missed");
  AST_RELOC: assert property (glob_en && map_enable_primary_r[EN1_RELOCATE] &&
      below_1m && seg == SEG_B && win_en[{2'd2, qtr}] |-> page_hit)
    else $error("relocated b window not translated");
endmodule

/* sim/epm_host_model.sv */
`timescale 1ns/1ps
// ------
// host side: port software and cpu
// ------
module epm_host_model (
  // clock
  input  wire logic        clk,
  // i/o port bus
  output logic      [15:0] io_addr,
  output logic             io_rd,
  output logic             io_wr,
  output logic      [7:0]  io_wdata,
  // cpu cycle
  output logic             cpu_valid,
  output logic             cpu_wr,
  output logic      [23:0] cpu_addr
);
  // quiet bus at time zero
  initial begin
    {io_addr, io_rd, io_wr, io_wdata, cpu_valid, cpu_wr, cpu_addr} = '0;
  end
  // byte access: one strobe cycle, idle cycle before the next
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    {io_wr, io_rd} = {w, ~w};
    @(posedge clk);
    #1;
    {io_wr, io_rd} = 2'b00;
    io_addr = ~a; // released lines never keep the old value
    io_wdata = ~d;
  endtask
  // memory cycle; answer stands for the one cycle after the edge following the take
  task automatic cpu(input logic w, input logic [23:0] a);
    @(posedge clk);
    #1;
    cpu_valid = 1'b1;
    cpu_wr = w;
    cpu_addr = a;
    @(posedge clk);
    #1;
    cpu_valid = 1'b0;
    cpu_addr = ~a;
    @(posedge clk);
    #1;
  endtask
endmodule

/* sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import epm_pkg::*;
  // ------
  // design and host
  // ------
  logic        clk, arst_n, io_rd, io_wr, io_ack_r, cpu_valid, cpu_wr;
  logic        mem_valid_r, mem_wr_r, mem_translated_r;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata_r;
  logic [23:0] cpu_addr, a;
  logic [24:0] mem_phys_r;
  logic [1:0]  c;
  epm_dest_e   mem_dest_r;
  logic [10:0] pg [36];
  int          fail_count, checked, seed, cyc, k;
  epm_mapper uut (.clk, .arst_n, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata_r,
    .io_ack_r, .cpu_valid, .cpu_wr, .cpu_addr, .mem_valid_r, .mem_wr_r,
    .mem_translated_r, .mem_dest_r, .mem_phys_r);
  epm_host_model m (.clk, .io_addr, .io_rd, .io_wr, .io_wdata, .cpu_valid, .cpu_wr,
    .cpu_addr);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // hang guard, far above the roughly 520 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic chk(input logic ok, input string s);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("CHECK FAILED t=%0t %s", $time, s);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    m.io(1'b1, IO_CFG_INDEX, i);
    m.io(1'b1, IO_CFG_DATA, d);
  endtask
  // base of window n, plain or moved to a, d, b
  function automatic logic [23:0] win(int n, logic rel);
    if (!rel) return 24'h0c0000 + 24'(n) * 24'h4000;
    return {4'h0, n < 4 ? SEG_A : n < 8 ? SEG_D : SEG_B, 16'h0} + 24'(n % 4) * 24'h4000;
  endfunction
  // one cpu cycle and the outcome it must give
  task automatic xl(input logic w, input logic [23:0] ad, input logic tr,
                    input logic [10:0] p, input epm_dest_e d);
    m.cpu(w, ad);
    chk(mem_valid_r === 1'b1 && mem_wr_r === w && mem_translated_r === tr
        && mem_dest_r === d && mem_phys_r === (tr ? {p, ad[13:0]} : {1'b0, ad}), "cycle");
  endtask
  initial begin
    seed = 32'h0b10;
    arst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(io_ack_r === 1'b0 && mem_valid_r === 1'b0 && mem_dest_r === DEST_SLOT, "reset");
    m.io(1'b1, IO_PAGE_INDEX, 8'h05);
    m.io(1'b1, IO_UNLOCK, 8'h00);
    m.io(1'b0, IO_PAGE_INDEX, 8'h00);
    chk(io_ack_r === 1'b1 && io_rdata_r === INDEX_RST, "locked");
    m.io(1'b1, IO_PAGE_INDEX, 8'h40);
    for (int n = 0; n < 36; n++) begin
      pg[n] = 11'($random(seed));
      m.io(1'b1, IO_PAGE_LO, pg[n][7:0]);
      m.io(1'b1, IO_PAGE_HI, {5'h0, pg[n][10:8]});
    end
    m.io(1'b0, IO_PAGE_INDEX, 8'h00);
    chk(io_rdata_r === 8'h40, "wrap");
    m.io(1'b1, IO_PAGE_INDEX, 8'h80);
    m.io(1'b1, IO_PAGE_LO, ~pg[0][7:0]);
    m.io(1'b1, IO_PAGE_INDEX, 8'h40);
    for (int n = 0; n < 36; n++) begin
      m.io(1'b0, IO_PAGE_LO, 8'h00);
      chk(io_rdata_r === pg[n][7:0], "low");
      m.io(1'b0, IO_PAGE_HI, 8'h00);
      chk(io_rdata_r === {PAGE_HI_ONES, pg[n][10:8]}, "high");
    end
    m.io(1'b1, IO_PAGE_INDEX, 8'h80);
    m.io(1'b0, IO_PAGE_LO, 8'h00);
    chk(io_rdata_r === ~pg[0][7:0], "bank");
    m.io(1'b1, IO_PAGE_HI, {5'h0, pg[0][10:8]});
    $display("page store test done");
    cfg(CFG_SLOT_PTR, 8'h10);
    cfg(CFG_MAP_EN_SEC, 8'hff);
    for (int r = 0; r < 2; r++) begin
      cfg(CFG_MAP_EN_PRI, r ? 8'h9f : 8'h8f);
      for (int n = 0; n < 12; n++)
        xl(r[0], win(n, r[0]) + 24'($random(seed) & 16'h3fff), 1'b1, pg[n], DEST_BOARD);
    end
    cfg(CFG_MAP_EN_SEC, 8'hfe);
    xl(1'b0, 24'h0a0000, 1'b0, '0, DEST_SLOT);
    cfg(CFG_MAP_EN_PRI, 8'h4f);
    cfg(CFG_SHADOW_BASE + 8'h02, 8'h78);
    for (int n = 0; n < 8; n++) begin
      c = 2'(8'h78 >> (2 * (n / 2)));
      xl(n[0], 24'h0c0000 + 24'(n / 2) * 24'h4000, 1'b0, '0,
         (n[0] ? c[0] : c[1]) ? DEST_BOARD : DEST_SLOT);
    end
    xl(1'b0, 24'h040000, 1'b0, '0, DEST_BOARD);
    cfg(CFG_MAP_EN_PRI, 8'h8f);
    xl(1'b1, 24'h0c4321, 1'b1, pg[1], DEST_BOARD);
    cfg(CFG_MAP_EN_SEC, 8'hff);
    cfg(CFG_CTX_SELECT, 8'h01);
    xl(1'b0, 24'h0c0123, 1'b1, {pg[0][10:8], ~pg[0][7:0]}, DEST_BOARD);
    cfg(CFG_CTX_SELECT, 8'h00);
    $display("window test done");
    cfg(CFG_MAP_EN_PRI, 8'hc0);
    k = {$random(seed)} % 24;
    a = 24'h040000 + 24'(k) * 24'h4000 + 24'h0123;
    xl(1'b0, a, 1'b1, pg[12 + k], DEST_BOARD);
    cfg(CFG_SLOT_PTR, 8'h05);
    m.io(1'b1, IO_CFG_INDEX, CFG_MAP_EN_PRI);
    m.io(1'b0, IO_CFG_DATA, 8'h00);
    chk(io_rdata_r === 8'h80, "bf clear");
    xl(1'b0, 24'h040000, 1'b0, '0, DEST_BOARD);
    xl(1'b1, 24'h060000, 1'b0, '0, DEST_SLOT);
    cfg(CFG_MAP_EN_PRI, 8'hc0);
    cfg(CFG_SLOT_PTR, 8'h0a);
    xl(1'b0, a, 1'b1, pg[12 + k], DEST_BOARD);
    cfg(CFG_SLOT_PTR, 8'h20);
    xl(1'b0, 24'h150000, 1'b0, '0, DEST_BOARD);
    xl(1'b0, 24'h250000, 1'b0, '0, DEST_SLOT);
    m.io(1'b1, IO_LOCK, 8'h00);
    $display("slot pointer test done");
    give_verdict();
  end
endmodule
